// *** verilog/dim_pkg.sv ***
/*
 * Shared constants and carriers for the digital input process-data map.
 * Assumes a Modbus front end that has already split each request into
 * function code, map address and register index within a block of ten.
 */
package dim_pkg;

	// function codes
	localparam logic [7:0] DIM_FC_READ_HOLD = 8'h03;
	localparam logic [7:0] DIM_FC_READ_INPUT = 8'h04;
	localparam logic [7:0] DIM_FC_WRITE_HOLD = 8'h10;

	// register index inside a block
	localparam logic [3:0] DIM_IDX_STATUS = 4'h0;
	localparam logic [3:0] DIM_IDX_LEVELS = 4'h1;
	localparam logic [3:0] DIM_IDX_ONE_LO = 4'h2;
	localparam logic [3:0] DIM_IDX_ONE_HI = 4'h3;
	localparam logic [3:0] DIM_IDX_SEVEN_LO = 4'h4;
	localparam logic [3:0] DIM_IDX_SEVEN_HI = 4'h5;
	localparam logic [3:0] DIM_IDX_LAST = 4'h9;
	localparam logic [3:0] DIM_IDX_CLEAR = 4'h1;

	// selector wheel range, two decimal digits
	localparam logic [6:0] DIM_MAP_LAST = 7'h63;

	// field positions
	localparam int DIM_STALE_BIT = 8;
	localparam int DIM_CLR_ONE_BIT = 0;
	localparam int DIM_CLR_SEVEN_BIT = 1;
	localparam int DIM_CH_ONE = 0;
	localparam int DIM_CH_SEVEN = 6;

	// reset values
	localparam logic [31:0] DIM_COUNT_RESET = 32'h0000_0000;
	localparam logic [7:0] DIM_LEVELS_RESET = 8'h00;
	localparam logic [15:0] DIM_WORD_ZERO = 16'h0000;

	typedef enum logic [1:0] {
		DIM_MODE_FOUR = 2'b00,
		DIM_MODE_EIGHT_STATIC = 2'b01,
		DIM_MODE_EIGHT_PULSE = 2'b10
	} dim_mode_e;

	typedef struct packed {
		logic valid;
		logic [7:0] fc;
		logic [6:0] map;
		logic [3:0] index;
		logic [15:0] wdata;
	} dim_req_s;

	typedef struct packed {
		logic valid;
		logic err;
		logic [15:0] data;
	} dim_rsp_s;

	typedef struct packed {
		logic stale;
		logic [7:0] levels;
		logic [7:0] prev;
		logic [31:0] count_one;
		logic [31:0] count_seven;
		dim_rsp_s rsp;
	} dim_state_s;

endpackage

// *** verilog/dim_map.sv ***
/*
 * Process-data register image of a four or eight channel digital input
 * module: status, static levels, two pulse counters and their clear word.
 * Assumes request fields, link health and input levels are synchronous to
 * clk and that one request is offered per cycle at most.
 */
module dim_map
	import dim_pkg::*;
#(
	// arbitrary neutral values
	parameter logic [7:0] TYPE_FOUR = 8'hA1,
	parameter logic [7:0] TYPE_EIGHT_STATIC = 8'hA2,
	parameter logic [7:0] TYPE_EIGHT_PULSE = 8'hA3
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [6:0] map_address,
	input wire logic eight_ch,
	input wire logic pulse_mode,
	input wire logic link_ok,
	input wire logic [7:0] input_levels,
	input wire dim_req_s req,
	output dim_rsp_s rsp
);

	dim_state_s s_q;
	dim_state_s s_d;
	dim_mode_e mode;
	logic [7:0] rise;
	logic clr_one;
	logic clr_seven;
	logic hit;

	function automatic logic [7:0] type_code(input dim_mode_e m);
		unique case (m)
			DIM_MODE_FOUR: type_code = TYPE_FOUR;
			DIM_MODE_EIGHT_STATIC: type_code = TYPE_EIGHT_STATIC;
			DIM_MODE_EIGHT_PULSE: type_code = TYPE_EIGHT_PULSE;
			default: type_code = 8'h00;
		endcase
	endfunction

	function automatic logic [15:0] input_word(input dim_state_s st, input dim_mode_e m, input logic [3:0] idx);
		logic pulse;
		pulse = (m == DIM_MODE_EIGHT_PULSE);
		input_word = DIM_WORD_ZERO;
		unique case (idx)
			DIM_IDX_STATUS: begin
				input_word = {7'h00, st.stale, type_code(m)};
			end
			DIM_IDX_LEVELS: begin
				if (m == DIM_MODE_FOUR) begin
					input_word = {12'h000, st.levels[3:0]};
				end else begin
					input_word = {8'h00, st.levels};
				end
			end
			DIM_IDX_ONE_LO: input_word = pulse ? st.count_one[15:0] : DIM_WORD_ZERO;
			DIM_IDX_ONE_HI: input_word = pulse ? st.count_one[31:16] : DIM_WORD_ZERO;
			DIM_IDX_SEVEN_LO: input_word = pulse ? st.count_seven[15:0] : DIM_WORD_ZERO;
			DIM_IDX_SEVEN_HI: input_word = pulse ? st.count_seven[31:16] : DIM_WORD_ZERO;
			default: input_word = DIM_WORD_ZERO;
		endcase
	endfunction

	always_comb begin
		if (!eight_ch) begin
			mode = DIM_MODE_FOUR;
		end else if (pulse_mode) begin
			mode = DIM_MODE_EIGHT_PULSE;
		end else begin
			mode = DIM_MODE_EIGHT_STATIC;
		end
	end

	// inputs arrive synchronous, so the edge detector may look at them directly
	assign rise = input_levels & ~s_q.prev;
	assign hit = req.valid && (req.map == map_address) && (req.map <= DIM_MAP_LAST)
		&& (req.index <= DIM_IDX_LAST);
	assign clr_one = hit && (req.fc == DIM_FC_WRITE_HOLD) && (mode == DIM_MODE_EIGHT_PULSE)
		&& (req.index == DIM_IDX_CLEAR) && req.wdata[DIM_CLR_ONE_BIT];
	assign clr_seven = hit && (req.fc == DIM_FC_WRITE_HOLD) && (mode == DIM_MODE_EIGHT_PULSE)
		&& (req.index == DIM_IDX_CLEAR) && req.wdata[DIM_CLR_SEVEN_BIT];

	always_comb begin
		s_d = s_q;
		s_d.prev = input_levels;
		s_d.stale = !link_ok;
		if (link_ok) begin
			s_d.levels = input_levels;
		end
		// a pulse in the clearing cycle is kept: the count restarts at one
		if (clr_one) begin
			s_d.count_one = DIM_COUNT_RESET;
		end
		if (clr_seven) begin
			s_d.count_seven = DIM_COUNT_RESET;
		end
		if (link_ok && mode == DIM_MODE_EIGHT_PULSE) begin
			if (rise[DIM_CH_ONE]) begin
				s_d.count_one = s_d.count_one + 32'h0000_0001;
			end
			if (rise[DIM_CH_SEVEN]) begin
				s_d.count_seven = s_d.count_seven + 32'h0000_0001;
			end
		end
		s_d.rsp.valid = req.valid;
		s_d.rsp.err = 1'b0;
		s_d.rsp.data = DIM_WORD_ZERO;
		if (req.valid) begin
			if (!hit) begin
				s_d.rsp.err = 1'b1;
			end else if (req.fc == DIM_FC_READ_INPUT) begin
				s_d.rsp.data = input_word(s_q, mode, req.index);
			end else if (mode != DIM_MODE_EIGHT_PULSE) begin
				s_d.rsp.err = 1'b1;
			end else if (req.fc == DIM_FC_READ_HOLD) begin
				// clear bits act once and read back as zero
				s_d.rsp.data = (req.index == DIM_IDX_STATUS) ? input_word(s_q, mode, DIM_IDX_STATUS)
					: DIM_WORD_ZERO;
			end else if (req.fc == DIM_FC_WRITE_HOLD) begin
				s_d.rsp.err = (req.index != DIM_IDX_CLEAR);
				s_d.rsp.data = req.wdata;
			end else begin
				s_d.rsp.err = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '{stale: 1'b1, levels: DIM_LEVELS_RESET, prev: DIM_LEVELS_RESET,
				count_one: DIM_COUNT_RESET, count_seven: DIM_COUNT_RESET,
				rsp: '{valid: 1'b0, err: 1'b0, data: DIM_WORD_ZERO}};
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp = s_q.rsp;

	logic rd_in;
	logic pulse_now;
	assign rd_in = hit && req.fc == DIM_FC_READ_INPUT;
	assign pulse_now = (mode == DIM_MODE_EIGHT_PULSE);

	sequence s_write_clear(int bitpos);
		hit && pulse_now && req.fc == DIM_FC_WRITE_HOLD && req.index == DIM_IDX_CLEAR && req.wdata[bitpos];
	endsequence

	// answer of a refused request, one cycle after it is taken
	sequence s_refused;
		rsp.valid && rsp.err;
	endsequence

	property p_stale_flag;
		@(posedge clk) disable iff (reset)
		rd_in && req.index == DIM_IDX_STATUS |=> rsp.valid && rsp.data[DIM_STALE_BIT] == !$past(link_ok, 2);
	endproperty
	a_stale_flag: assert property (p_stale_flag) else $error("stale flag wrong");

	property p_hold_image;
		@(posedge clk) disable iff (reset)
		!link_ok [*2] |=> $stable(s_q.levels) && s_q.stale;
	endproperty
	a_hold_image: assert property (p_hold_image) else $error("image changed while link down");

	property p_type_code;
		@(posedge clk) disable iff (reset)
		rd_in && req.index == DIM_IDX_STATUS |=> rsp.data[7:0] == type_code($past(mode)) && rsp.data[15:9] == 7'h00;
	endproperty
	a_type_code: assert property (p_type_code) else $error("status type wrong");

	property p_four_levels;
		@(posedge clk) disable iff (reset)
		rd_in && req.index == DIM_IDX_LEVELS && !eight_ch
		|=> rsp.data == {12'h000, $past(s_q.levels[3:0])} && !rsp.err;
	endproperty
	a_four_levels: assert property (p_four_levels) else $error("four channel levels wrong");

	property p_eight_levels;
		@(posedge clk) disable iff (reset)
		rd_in && req.index == DIM_IDX_LEVELS && eight_ch && !pulse_mode
		|=> rsp.data == {8'h00, $past(s_q.levels)};
	endproperty
	a_eight_levels: assert property (p_eight_levels) else $error("eight channel levels wrong");

	property p_count_words;
		@(posedge clk) disable iff (reset)
		rd_in && pulse_now && req.index == DIM_IDX_SEVEN_HI |=> rsp.data == $past(s_q.count_seven[31:16]);
	endproperty
	a_count_words: assert property (p_count_words) else $error("count word wrong");

	property p_clear_one;
		@(posedge clk) disable iff (reset)
		s_write_clear(DIM_CLR_ONE_BIT) |=> s_q.count_one <= 32'h0000_0001 && rsp.valid && !rsp.err;
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("channel one not cleared");

	property p_clear_seven;
		@(posedge clk) disable iff (reset)
		s_write_clear(DIM_CLR_SEVEN_BIT) |=> s_q.count_seven <= 32'h0000_0001 && !rsp.err;
	endproperty
	a_clear_seven: assert property (p_clear_seven) else $error("channel seven not cleared");

	property p_reserved;
		@(posedge clk) disable iff (reset)
		rd_in && (req.index > DIM_IDX_SEVEN_HI || (!pulse_now && req.index > DIM_IDX_LEVELS))
		|=> rsp.data == DIM_WORD_ZERO && !rsp.err;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved word not zero");

	property p_map_match;
		@(posedge clk) disable iff (reset)
		req.valid && req.map != map_address |=> rsp.valid && rsp.err && rsp.data == DIM_WORD_ZERO;
	endproperty
	a_map_match: assert property (p_map_match) else $error("foreign map address served");

	property p_count_step;
		@(posedge clk) disable iff (reset)
		link_ok && pulse_now && !clr_one && rise[DIM_CH_ONE] |=> s_q.count_one == $past(s_q.count_one) + 32'h0000_0001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step");

	property p_count_hold;
		@(posedge clk) disable iff (reset)
		!clr_seven && !(link_ok && pulse_now && rise[DIM_CH_SEVEN]) |=> $stable(s_q.count_seven);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved without pulse");

	property p_answer_valid;
		@(posedge clk) disable iff (reset)
		req.valid |=> rsp.valid;
	endproperty
	a_answer_valid: assert property (p_answer_valid) else $error("request not answered");

	// nothing asked, nothing shown: a stale word cannot look like an answer
	property p_answer_idle;
		@(posedge clk) disable iff (reset)
		!req.valid |=> !rsp.valid && !rsp.err && rsp.data == DIM_WORD_ZERO;
	endproperty
	a_answer_idle: assert property (p_answer_idle) else $error("answer without request");

	property p_bad_fc;
		@(posedge clk) disable iff (reset)
		req.valid && req.fc != DIM_FC_READ_HOLD && req.fc != DIM_FC_READ_INPUT && req.fc != DIM_FC_WRITE_HOLD
		|=> s_refused;
	endproperty
	a_bad_fc: assert property (p_bad_fc) else $error("unknown function code served");

	property p_bad_index;
		@(posedge clk) disable iff (reset)
		req.valid && req.index > DIM_IDX_LAST |=> s_refused;
	endproperty
	a_bad_index: assert property (p_bad_index) else $error("index beyond block served");

	property p_hold_static;
		@(posedge clk) disable iff (reset)
		hit && !pulse_now && req.fc != DIM_FC_READ_INPUT |=> s_refused;
	endproperty
	a_hold_static: assert property (p_hold_static) else $error("holding word served outside pulse mode");

	property p_hold_read;
		@(posedge clk) disable iff (reset)
		hit && pulse_now && req.fc == DIM_FC_READ_HOLD && req.index == DIM_IDX_CLEAR
		|=> rsp.data == DIM_WORD_ZERO && !rsp.err;
	endproperty
	a_hold_read: assert property (p_hold_read) else $error("clear word not read as zero");

	property p_write_echo;
		@(posedge clk) disable iff (reset)
		hit && pulse_now && req.fc == DIM_FC_WRITE_HOLD && req.index == DIM_IDX_CLEAR
		|=> rsp.data == $past(req.wdata) && !rsp.err;
	endproperty
	a_write_echo: assert property (p_write_echo) else $error("clear write not echoed");

	property p_stale_clear;
		@(posedge clk) disable iff (reset)
		link_ok |=> !s_q.stale;
	endproperty
	a_stale_clear: assert property (p_stale_clear) else $error("stale flag kept with link up");

	property p_levels_track;
		@(posedge clk) disable iff (reset)
		link_ok |=> s_q.levels == $past(input_levels);
	endproperty
	a_levels_track: assert property (p_levels_track) else $error("levels not refreshed");

	property p_seven_step;
		@(posedge clk) disable iff (reset)
		link_ok && pulse_now && !clr_seven && rise[DIM_CH_SEVEN]
		|=> s_q.count_seven == $past(s_q.count_seven) + 32'h0000_0001;
	endproperty
	a_seven_step: assert property (p_seven_step) else $error("channel seven did not step");

	property p_one_hold;
		@(posedge clk) disable iff (reset)
		!clr_one && !(link_ok && pulse_now && rise[DIM_CH_ONE]) |=> $stable(s_q.count_one);
	endproperty
	a_one_hold: assert property (p_one_hold) else $error("channel one moved without pulse");

endmodule

// *** test/dim_master.sv ***
/*
 * Modbus master model: offers one request on dim_req_s and collects
 * the registered answer. Assumes rsp holds the answer just after the taking edge.
 */
module dim_master
	import dim_pkg::*;
(
	input wire logic clk,
	output dim_req_s req,
	input wire dim_rsp_s rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	// released fields go inverted so a stale sample cannot pass by luck
	task automatic xfer(input logic [7:0] fc, input logic [6:0] mp, input logic [3:0] ix,
		input logic [15:0] wd, output logic [15:0] d, output logic e);
		@(posedge clk);
		#1 req = '{1'b1, fc, mp, ix, wd};
		@(posedge clk);
		#1 d = rsp.data;
		e = (rsp.valid === 1'b1) ? rsp.err : 1'bx;
		req = '{1'b0, ~fc, ~mp, ~ix, ~wd};
	endtask
endmodule

// *** test/dim_map_test.sv ***
/*
 * Self-checking bench for the digital input register image.
 * Assumes the dim_master model and default type code parameters.
 */
module dim_map_test
	import dim_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic reset = 1;
	logic eight_ch = 0;
	logic pulse_mode = 0;
	logic link_ok = 0;
	logic [6:0] map_address = 7'h2A;
	logic [7:0] input_levels = 8'h00;
	dim_req_s req;
	dim_rsp_s rsp;
	int err_total = 0;
	int num_checks = 0;
	logic [15:0] d;
	logic e;
	always #25 clk = ~clk;
	dim_map dut(.clk(clk), .reset(reset), .map_address(map_address), .eight_ch(eight_ch),
		.pulse_mode(pulse_mode), .link_ok(link_ok), .input_levels(input_levels), .req(req), .rsp(rsp));
	dim_master m(.clk(clk), .req(req), .rsp(rsp));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_err(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t err flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [3:0] ix, input logic [15:0] exp);
		m.xfer(DIM_FC_READ_INPUT, map_address, ix, 16'h0000, d, e);
		chk_err(e, 1'b0);
		chk(d, exp);
	endtask
	task automatic wr(input logic [15:0] wd);
		m.xfer(DIM_FC_WRITE_HOLD, map_address, DIM_IDX_CLEAR, wd, d, e);
		chk_err(e, 1'b0);
		chk(d, wd);
	endtask
	task automatic nope(input logic [7:0] fc, input logic [6:0] mp, input logic [3:0] ix);
		m.xfer(fc, mp, ix, 16'h0003, d, e);
		chk_err(e, 1'b1);
	endtask
	task automatic pulse(input int b, input int n);
		repeat (n) begin
			input_levels[b] = 1'b1;
			cyc(1);
			input_levels[b] = 1'b0;
			cyc(1);
		end
		cyc(2);
	endtask
	task automatic t_four;
		input_levels = 8'hFA;
		cyc(2);
		rd(DIM_IDX_LEVELS, 16'h000A);
		rd(DIM_IDX_STATUS, 16'h00A1);
		for (int i = 2; i <= 9; i++) rd(4'(i), 16'h0000);
		link_ok = 0;
		input_levels = 8'h05;
		cyc(2);
		rd(DIM_IDX_STATUS, 16'h01A1);
		rd(DIM_IDX_LEVELS, 16'h000A);
		link_ok = 1;
		cyc(2);
	endtask
	task automatic t_eight;
		eight_ch = 1;
		input_levels = 8'hA5;
		cyc(2);
		rd(DIM_IDX_LEVELS, 16'h00A5);
		rd(DIM_IDX_STATUS, 16'h00A2);
		nope(DIM_FC_READ_HOLD, map_address, DIM_IDX_CLEAR);
	endtask
	task automatic t_pulse;
		pulse_mode = 1;
		input_levels = 8'h00;
		cyc(2);
		rd(DIM_IDX_STATUS, 16'h00A3);
		pulse(0, 3);
		pulse(6, 2);
		rd(DIM_IDX_ONE_LO, 16'h0003);
		rd(DIM_IDX_ONE_HI, 16'h0000);
		rd(DIM_IDX_SEVEN_LO, 16'h0002);
		rd(DIM_IDX_SEVEN_HI, 16'h0000);
		for (int i = 6; i <= 9; i++) rd(4'(i), 16'h0000);
		wr(16'h0001);
		rd(DIM_IDX_ONE_LO, 16'h0000);
		rd(DIM_IDX_SEVEN_LO, 16'h0002);
		wr(16'h0002);
		rd(DIM_IDX_SEVEN_LO, 16'h0000);
		m.xfer(DIM_FC_READ_HOLD, map_address, DIM_IDX_CLEAR, 16'h0000, d, e);
		chk_err(e, 1'b0);
		chk(d, 16'h0000);
		pulse(0, 1);
		nope(DIM_FC_WRITE_HOLD, map_address + 7'h01, DIM_IDX_CLEAR);
		nope(DIM_FC_WRITE_HOLD, map_address, DIM_IDX_ONE_LO);
		nope(8'h06, map_address, DIM_IDX_CLEAR);
		nope(DIM_FC_READ_INPUT, map_address, 4'hA);
		rd(DIM_IDX_ONE_LO, 16'h0001);
		link_ok = 0;
		pulse(0, 1);
		rd(DIM_IDX_ONE_LO, 16'h0001);
		link_ok = 1;
		map_address = DIM_MAP_LAST;
		cyc(2);
		rd(DIM_IDX_STATUS, 16'h00A3);
		nope(DIM_FC_READ_INPUT, 7'h64, DIM_IDX_STATUS);
	endtask
	// second reset in mid-run: counts restart, stale drops once the link is seen
	task automatic t_reset;
		pulse(6, 1);
		rd(DIM_IDX_SEVEN_LO, 16'h0001);
		reset = 1;
		cyc(2);
		reset = 0;
		cyc(2);
		rd(DIM_IDX_SEVEN_LO, 16'h0000);
		rd(DIM_IDX_STATUS, 16'h00A3);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// watchdog: a hang is cut short here
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("ERROR %0t run did not finish", $time);
		final_report;
	end
	initial begin
		cyc(3);
		reset = 0;
		link_ok = 1;
		t_four;
		t_eight;
		t_pulse;
		t_reset;
		final_report;
	end
endmodule
